// ===== rtl/vfdsl_top.sv
// grid sequencer and segment latch for a multiplexed fluorescent display
//
// Summary of operation
// - seven-stage twisted-ring counter returns to its start state on sync rising edge
// - counter steps one state on every rising edge of the sequencer clock, except when sync rises in the same cycle
// - one of fourteen grids active at a time, in order, one clock each
// - all grids off while either blanking gate is high
// - counter keeps counting and resetting while blanked; only outputs are gated
// - delayed gate holds blanking for a set interval after falling; direct gate does not
// - fourteen-bit shift register takes one data bit per shift clock rising edge while the latch is enabled
// - strobe leading edge makes one pulse copying the shift register into output latches
// - each segment output follows its latch; any combination may be on
// - latch enabled when high enable is one or low enable is zero
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module vfdsl_top #(
    parameter int unsigned STAGES = vfdsl_pkg::VFDSL_STAGES,
    parameter logic [vfdsl_pkg::VFDSL_DLY_W-1:0] DELAY_RESET = vfdsl_pkg::VFDSL_DLY_RST
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    input wire logic I_LINK_CLK,
    input wire logic [vfdsl_pkg::VFDSL_ADDR_W-1:0] I_REG_ADDR,
    input wire logic [vfdsl_pkg::VFDSL_DATA_W-1:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [vfdsl_pkg::VFDSL_DATA_W-1:0] O_REG_RDATA,
    input wire vfdsl_pkg::vfdsl_pins_s I_PINS,
    output logic [vfdsl_pkg::VFDSL_GRIDS-1:0] O_GRID,
    output logic [vfdsl_pkg::VFDSL_SEGS-1:0] O_SEGMENT
);
    import vfdsl_pkg::*;

    localparam int unsigned PIN_W = $bits(vfdsl_pins_s);
    localparam int unsigned STAT_W = $bits(vfdsl_link_stat_s);
    localparam int unsigned GRIDS = 2 * STAGES;

    // the ports and index field are sized for the documented counter length
    if (STAGES != VFDSL_STAGES || GRIDS > (1 << VFDSL_IDX_W)) begin : g_bad_stages
        $error("vfdsl_top: STAGES must match the grid port width");
    end

    // ------------------------------------------------------------------
    // resets: each domain gets its own released copy of the pin
    // ------------------------------------------------------------------
    logic core_rst_s1_r;
    logic core_rst_n_r;
    logic link_rst_s1_r;
    logic link_rst_n_r;

    // core reset release, asserted at once, removed after two edges
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            core_rst_s1_r <= 1'b0;
            core_rst_n_r <= 1'b0;
        end else begin
            core_rst_s1_r <= 1'b1;
            core_rst_n_r <= core_rst_s1_r;
        end
    end

    // link reset release, same scheme on the link clock
    always_ff @(posedge I_LINK_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            link_rst_s1_r <= 1'b0;
            link_rst_n_r <= 1'b0;
        end else begin
            link_rst_s1_r <= 1'b1;
            link_rst_n_r <= link_rst_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // core domain: register port
    // ------------------------------------------------------------------
    logic [VFDSL_DLY_W-1:0] blank_delay_r;
    logic [VFDSL_DATA_W-1:0] rdata_r;
    logic [VFDSL_DATA_W-1:0] rdata_nxt;
    vfdsl_link_stat_s core_stat;
    vfdsl_ctrl_reg_s ctrl_view;
    vfdsl_status_reg_s status_view;
    vfdsl_segs_reg_s segs_view;
    vfdsl_ctrl_reg_s ctrl_wr;

    // address decode
    wire ctrl_hit = (I_REG_ADDR == VFDSL_ADDR_CTRL);
    wire status_hit = (I_REG_ADDR == VFDSL_ADDR_STATUS);
    wire segs_hit = (I_REG_ADDR == VFDSL_ADDR_SEGS);
    wire ctrl_wr_en = I_REG_WR && ctrl_hit;

    // register views, reserved bits read as zero
    assign ctrl_wr = vfdsl_ctrl_reg_s'(I_REG_WDATA);
    assign ctrl_view.reserved = '0;
    assign ctrl_view.blank_delay = blank_delay_r;
    assign status_view.reserved = '0;
    assign status_view.strobe_cnt = core_stat.strobe_cnt;
    assign status_view.blanked = core_stat.blanked;
    assign status_view.grid_idx = core_stat.grid_idx;
    assign segs_view.reserved = '0;
    assign segs_view.segments = core_stat.segments;

    // read select; unmapped addresses and idle cycles answer zero
    assign rdata_nxt = !I_REG_RD ? '0 :
                       ctrl_hit ? VFDSL_DATA_W'(ctrl_view) :
                       status_hit ? VFDSL_DATA_W'(status_view) :
                       segs_hit ? VFDSL_DATA_W'(segs_view) : '0;

    // writes to anything but the control word are dropped
    always_ff @(posedge I_CORE_CLK or negedge core_rst_n_r) begin
        if (!core_rst_n_r) begin
            blank_delay_r <= DELAY_RESET;
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
            if (ctrl_wr_en) begin
                blank_delay_r <= ctrl_wr.blank_delay;
            end
        end
    end

    assign O_REG_RDATA = rdata_r;

    // ------------------------------------------------------------------
    // domain crossings
    // ------------------------------------------------------------------
    logic [VFDSL_DLY_W-1:0] link_blank_delay;
    vfdsl_link_stat_s link_stat;
    logic [STAT_W-1:0] core_stat_bits;

    // delay setting: slow-changing word, handshake keeps it coherent
    vfdsl_word_xfer #(
        .W(VFDSL_DLY_W)
    ) u_delay_xfer (
        .i_src_clk(I_CORE_CLK),
        .i_src_rst_n(core_rst_n_r),
        .i_src_word(blank_delay_r),
        .i_dst_clk(I_LINK_CLK),
        .i_dst_rst_n(link_rst_n_r),
        .o_dst_word(link_blank_delay)
    );

    // status snapshot: software may see it a few cycles stale
    vfdsl_word_xfer #(
        .W(STAT_W)
    ) u_status_xfer (
        .i_src_clk(I_LINK_CLK),
        .i_src_rst_n(link_rst_n_r),
        .i_src_word(link_stat),
        .i_dst_clk(I_CORE_CLK),
        .i_dst_rst_n(core_rst_n_r),
        .o_dst_word(core_stat_bits)
    );

    assign core_stat = vfdsl_link_stat_s'(core_stat_bits);

    // ------------------------------------------------------------------
    // link domain: pin sampling and edge detection
    // ------------------------------------------------------------------
    logic [PIN_W-1:0] pin_level;
    vfdsl_pins_s pin_f;
    vfdsl_pins_s pin_prev_r;

    // all controller pins are asynchronous to the link clock
    vfdsl_pin_sync #(
        .W(PIN_W)
    ) u_pin_sync (
        .i_clk(I_LINK_CLK),
        .i_rst_n(link_rst_n_r),
        .i_async(I_PINS),
        .o_level(pin_level)
    );

    assign pin_f = vfdsl_pins_s'(pin_level);

    // previous filtered level for edge detection
    always_ff @(posedge I_LINK_CLK or negedge link_rst_n_r) begin
        if (!link_rst_n_r) begin
            pin_prev_r <= '0;
        end else begin
            pin_prev_r <= pin_f;
        end
    end

    // edges; data and clocks share one synchroniser so they stay aligned
    wire sync_rise = pin_f.sync && !pin_prev_r.sync;
    wire seq_rise = pin_f.seq_clk && !pin_prev_r.seq_clk;
    wire shift_rise = pin_f.shift_clk && !pin_prev_r.shift_clk;
    wire strobe_rise = pin_f.strobe && !pin_prev_r.strobe;
    wire gate_delayed_fall = !pin_f.blank_gate_delayed && pin_prev_r.blank_gate_delayed;

    // ------------------------------------------------------------------
    // sequencer: twisted-ring counter and grid decode
    // ------------------------------------------------------------------

    // legal ring states have at most one boundary between ones and zeros
    function automatic logic jc_legal(input logic [STAGES-1:0] q);
        int unsigned flips;
        flips = 0;
        for (int unsigned i = 0; i + 1 < STAGES; i++) begin
            if (q[i] != q[i+1]) begin
                flips++;
            end
        end
        return (flips <= 1);
    endfunction : jc_legal

    // ring state to grid position: fill phase counts up, drain phase beyond
    function automatic logic [VFDSL_IDX_W-1:0] jc_index(input logic [STAGES-1:0] q);
        int unsigned ones;
        ones = 0;
        for (int unsigned i = 0; i < STAGES; i++) begin
            ones += int'(q[i]);
        end
        if (q[STAGES-1]) begin
            return VFDSL_IDX_W'(GRIDS - ones);
        end
        return VFDSL_IDX_W'(ones);
    endfunction : jc_index

    logic [STAGES-1:0] jc_r;
    logic [STAGES-1:0] jc_step;
    logic [STAGES-1:0] jc_nxt;
    logic [VFDSL_IDX_W-1:0] grid_idx;
    logic [GRIDS-1:0] grid_sel;
    logic [GRIDS-1:0] grid_nxt;
    logic [GRIDS-1:0] grid_r;

    // shift in the inverted top stage; a corrupted state falls back to start
    assign jc_step = jc_legal(jc_r) ? {jc_r[STAGES-2:0], ~jc_r[STAGES-1]} : VFDSL_JOHNSON_INIT;

    // sync wins over a clock edge in the same cycle; blanking never enters here
    assign jc_nxt = sync_rise ? VFDSL_JOHNSON_INIT :
                    seq_rise ? jc_step : jc_r;

    always_ff @(posedge I_LINK_CLK or negedge link_rst_n_r) begin
        if (!link_rst_n_r) begin
            jc_r <= VFDSL_JOHNSON_INIT;
        end else begin
            jc_r <= jc_nxt;
        end
    end

    assign grid_idx = jc_index(jc_r);

    // one-hot grid select, one line per position
    for (genvar g = 0; g < GRIDS; g++) begin : g_grid
        assign grid_sel[g] = (grid_idx == VFDSL_IDX_W'(g));
    end

    // ------------------------------------------------------------------
    // blanking: direct gate releases at once, delayed gate after a hold
    // ------------------------------------------------------------------
    logic [VFDSL_DLY_W-1:0] hold_cnt_r;
    logic [VFDSL_DLY_W-1:0] hold_cnt_nxt;
    wire hold_busy = (hold_cnt_r != '0);

    // reload on the falling edge, clear while the gate is still high
    assign hold_cnt_nxt = pin_f.blank_gate_delayed ? '0 :
                          gate_delayed_fall ? link_blank_delay :
                          hold_busy ? hold_cnt_r - 1'b1 : hold_cnt_r;

    always_ff @(posedge I_LINK_CLK or negedge link_rst_n_r) begin
        if (!link_rst_n_r) begin
            hold_cnt_r <= '0;
        end else begin
            hold_cnt_r <= hold_cnt_nxt;
        end
    end

    // the fall cycle stays dark too, before the hold count has loaded
    wire blanked = pin_f.blank_gate_delayed || pin_f.blank_gate_direct || gate_delayed_fall || hold_busy;

    // gating acts after the decode so the counter is untouched
    assign grid_nxt = blanked ? '0 : grid_sel;

    // grid drivers come from flops to keep decode glitches off the pins
    always_ff @(posedge I_LINK_CLK or negedge link_rst_n_r) begin
        if (!link_rst_n_r) begin
            grid_r <= '0;
        end else begin
            grid_r <= grid_nxt;
        end
    end

    assign O_GRID = grid_r;

    // ------------------------------------------------------------------
    // segment latch: shift register, strobe one-shot, output latches
    // ------------------------------------------------------------------
    logic [VFDSL_SEGS-1:0] shreg_r;
    logic [VFDSL_SEGS-1:0] shreg_nxt;
    logic [VFDSL_SEGS-1:0] latch_r;
    logic [VFDSL_SEGS-1:0] latch_nxt;
    logic [VFDSL_CNT_W-1:0] strobe_cnt_r;

    // either enable pin may select this latch
    wire latch_enabled = pin_f.clock_enable_high || !pin_f.clock_enable_low;

    // newest bit enters at the bottom; the controller sends the last segment first
    assign shreg_nxt = (shift_rise && latch_enabled) ?
                       {shreg_r[VFDSL_SEGS-2:0], pin_f.ser_data} : shreg_r;

    // the edge detector is itself the one-shot: exactly one link cycle wide
    assign latch_nxt = strobe_rise ? shreg_r : latch_r;

    always_ff @(posedge I_LINK_CLK or negedge link_rst_n_r) begin
        if (!link_rst_n_r) begin
            shreg_r <= '0;
        end else begin
            shreg_r <= shreg_nxt;
        end
    end

    // strobe and shift in one cycle: the latch takes the old contents
    always_ff @(posedge I_LINK_CLK or negedge link_rst_n_r) begin
        if (!link_rst_n_r) begin
            latch_r <= '0;
            strobe_cnt_r <= '0;
        end else begin
            latch_r <= latch_nxt;
            if (strobe_rise) begin
                strobe_cnt_r <= strobe_cnt_r + 1'b1;
            end
        end
    end

    // every segment driven straight from its own latch bit
    assign O_SEGMENT = latch_r;

    // ------------------------------------------------------------------
    // status gathered for the core side
    // ------------------------------------------------------------------
    assign link_stat.strobe_cnt = strobe_cnt_r;
    assign link_stat.blanked = blanked;
    assign link_stat.grid_idx = grid_idx;
    assign link_stat.segments = latch_r;

endmodule : vfdsl_top
`default_nettype wire

// ===== rtl/vfdsl_pkg.sv
// shared constants, register layouts and carrier structs for the display sequencer and segment latch
package vfdsl_pkg;
    // sequencer counter and output widths
    localparam int unsigned VFDSL_STAGES = 7;
    localparam int unsigned VFDSL_GRIDS = 2 * VFDSL_STAGES;
    localparam int unsigned VFDSL_SEGS = 14;
    localparam int unsigned VFDSL_IDX_W = 4;
    localparam int unsigned VFDSL_DLY_W = 16;
    localparam int unsigned VFDSL_CNT_W = 8;

    // register port geometry and word offsets
    localparam int unsigned VFDSL_ADDR_W = 4;
    localparam int unsigned VFDSL_DATA_W = 32;
    localparam logic [VFDSL_ADDR_W-1:0] VFDSL_ADDR_CTRL = 4'h0;
    localparam logic [VFDSL_ADDR_W-1:0] VFDSL_ADDR_STATUS = 4'h4;
    localparam logic [VFDSL_ADDR_W-1:0] VFDSL_ADDR_SEGS = 4'h8;

    // reset values
    localparam logic [VFDSL_DLY_W-1:0] VFDSL_DLY_RST = 16'h0040;
    localparam logic [VFDSL_STAGES-1:0] VFDSL_JOHNSON_INIT = 7'h00;

    // controller pins as seen at the device
    typedef struct packed {
        logic sync;
        logic seq_clk;
        logic blank_gate_delayed;
        logic blank_gate_direct;
        logic shift_clk;
        logic ser_data;
        logic clock_enable_high;
        logic clock_enable_low;
        logic strobe;
    } vfdsl_pins_s;

    // link-side state mirrored into the core domain
    typedef struct packed {
        logic [VFDSL_CNT_W-1:0] strobe_cnt;
        logic blanked;
        logic [VFDSL_IDX_W-1:0] grid_idx;
        logic [VFDSL_SEGS-1:0] segments;
    } vfdsl_link_stat_s;

    // control register: blanking release delay in link clock cycles
    typedef struct packed {
        logic [VFDSL_DATA_W-VFDSL_DLY_W-1:0] reserved;
        logic [VFDSL_DLY_W-1:0] blank_delay;
    } vfdsl_ctrl_reg_s;

    // status register: sequencer position, blanking, strobe count
    typedef struct packed {
        logic [VFDSL_DATA_W-VFDSL_CNT_W-VFDSL_IDX_W-2:0] reserved;
        logic [VFDSL_CNT_W-1:0] strobe_cnt;
        logic blanked;
        logic [VFDSL_IDX_W-1:0] grid_idx;
    } vfdsl_status_reg_s;

    // segment register: output latch contents
    typedef struct packed {
        logic [VFDSL_DATA_W-VFDSL_SEGS-1:0] reserved;
        logic [VFDSL_SEGS-1:0] segments;
    } vfdsl_segs_reg_s;
endpackage : vfdsl_pkg

// ===== rtl/vfdsl_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module vfdsl_pin_sync #(
    parameter int unsigned W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_level
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] level_r;
    logic [W-1:0] level_nxt;

    // a bit moves only once stages two and three agree
    assign level_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & level_r);

    // first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            level_r <= '0;
        end else begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
        end
    end

    assign o_level = level_r;
endmodule : vfdsl_pin_sync
`default_nettype wire

// ===== rtl/vfdsl_word_xfer.sv
// toggle handshake that mirrors a word from one clock domain into another
`timescale 1ns/10ps
`default_nettype none
module vfdsl_word_xfer #(
    parameter int unsigned W = 8
) (
    input wire logic i_src_clk,
    input wire logic i_src_rst_n,
    input wire logic [W-1:0] i_src_word,
    input wire logic i_dst_clk,
    input wire logic i_dst_rst_n,
    output logic [W-1:0] o_dst_word
);
    logic [W-1:0] held_r;
    logic req_r;
    logic ack_s1_r;
    logic ack_s2_r;
    logic req_s1_r;
    logic req_s2_r;
    logic seen_r;
    logic [W-1:0] word_r;
    wire src_idle = (req_r == ack_s2_r);
    wire launch = src_idle && (i_src_word != held_r);
    wire arrive = (req_s2_r != seen_r);

    // source: hold the word stable until the far side has taken it
    always_ff @(posedge i_src_clk or negedge i_src_rst_n) begin
        if (!i_src_rst_n) begin
            held_r <= '0;
            req_r <= 1'b0;
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            ack_s1_r <= seen_r;
            ack_s2_r <= ack_s1_r;
            if (launch) begin
                held_r <= i_src_word;
                req_r <= ~req_r;
            end
        end
    end

    // destination: held word is quiet by the time the toggle lands
    always_ff @(posedge i_dst_clk or negedge i_dst_rst_n) begin
        if (!i_dst_rst_n) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            seen_r <= 1'b0;
            word_r <= '0;
        end else begin
            req_s1_r <= req_r;
            req_s2_r <= req_s1_r;
            if (arrive) begin
                seen_r <= req_s2_r;
                word_r <= held_r;
            end
        end
    end

    assign o_dst_word = word_r;
endmodule : vfdsl_word_xfer
`default_nettype wire

// ===== sim/vfdsl_chk.sv
// concurrent checks on the sequencer and segment latch ports
`timescale 1ns/10ps
`default_nettype none
module vfdsl_chk (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    input wire logic I_LINK_CLK,
    input wire logic I_REG_RD,
    input wire logic [vfdsl_pkg::VFDSL_DATA_W-1:0] O_REG_RDATA,
    input wire vfdsl_pkg::vfdsl_pins_s I_PINS,
    input wire logic [vfdsl_pkg::VFDSL_GRIDS-1:0] O_GRID,
    input wire logic [vfdsl_pkg::VFDSL_SEGS-1:0] O_SEGMENT
);
    import vfdsl_pkg::*;
    logic [3:0] since_step_r;
    logic [3:0] since_strb_r;
    logic [VFDSL_GRIDS-1:0] grid_q_r;
    // age of the last step or strobe edge; saturates so stale edges excuse nothing
    always_ff @(posedge I_LINK_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            since_step_r <= 4'hf;
            since_strb_r <= 4'hf;
            grid_q_r <= '0;
        end else begin
            since_step_r <= ($rose(I_PINS.seq_clk) || $rose(I_PINS.sync)) ? 4'h0 :
                (since_step_r == 4'hf) ? since_step_r : since_step_r + 4'h1;
            since_strb_r <= $rose(I_PINS.strobe) ? 4'h0 : (since_strb_r == 4'hf) ? since_strb_r : since_strb_r + 4'h1;
            grid_q_r <= O_GRID;
        end
    end
    chk_grid_one_hot: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N) $onehot0(O_GRID))
        else $error("more than one grid active");
    chk_blank_direct: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
        I_PINS.blank_gate_direct [*7] |-> O_GRID == '0) else $error("grid lit under direct blanking");
    chk_blank_delayed: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
        I_PINS.blank_gate_delayed [*7] |-> O_GRID == '0) else $error("grid lit under delayed blanking");
    chk_grid_step_cause: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
        (O_GRID != grid_q_r && O_GRID != '0 && grid_q_r != '0) |-> since_step_r <= 4'h9)
        else $error("grid moved without a clock or sync edge");
    chk_grid_step_order: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
        (O_GRID != grid_q_r && O_GRID != '0 && grid_q_r != '0) |->
        (O_GRID == {grid_q_r[12:0], grid_q_r[13]} || O_GRID == 14'h0001)) else $error("grid skipped a position");
    chk_sync_to_first: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
        ($rose(I_PINS.sync) && O_GRID != '0 && !I_PINS.blank_gate_direct && !I_PINS.blank_gate_delayed)
        |-> ##[4:8] O_GRID == 14'h0001) else $error("sync did not return to first grid");
    chk_seg_hold_strobe: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
        $changed(O_SEGMENT) |-> since_strb_r <= 4'h8) else $error("segments changed without strobe");
    chk_rdata_idle_zero: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
        !$past(I_REG_RD) |-> O_REG_RDATA == '0) else $error("read data outside read slot");
endmodule : vfdsl_chk
bind vfdsl_top vfdsl_chk i_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_LINK_CLK(I_LINK_CLK),
    .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA), .I_PINS(I_PINS), .O_GRID(O_GRID), .O_SEGMENT(O_SEGMENT));
`default_nettype wire

// ===== sim/vfdsl_ctrl_model.sv
// display controller model driving the sequencer and latch pins
`timescale 1ns/10ps
`default_nettype none
module vfdsl_ctrl_model (
    input wire logic i_link_clk,
    output var vfdsl_pkg::vfdsl_pins_s o_pins
);
    import vfdsl_pkg::*;
    localparam int P_SYNC = 8;
    localparam int P_STEP = 7;
    localparam int P_GDLY = 6;
    localparam int P_GDIR = 5;
    localparam int P_SCLK = 4;
    localparam int P_DATA = 3;
    localparam int P_CEH = 2;
    localparam int P_CEL = 1;
    localparam int P_STRB = 0;
    // idle: all low except the low-active enable, which holds the latch disabled
    initial begin
        o_pins = '0;
        o_pins.clock_enable_low = 1'b1;
    end
    // one pin change just after an edge, held four cycles so the filter sees it
    task automatic put(input int idx, input logic val);
        @(posedge i_link_clk);
        o_pins[idx] <= val;
        repeat (3) @(posedge i_link_clk);
    endtask : put
    task automatic sync_pulse();
        put(P_SYNC, 1'b1);
        put(P_SYNC, 1'b0);
    endtask : sync_pulse
    task automatic seq_step();
        put(P_STEP, 1'b1);
        put(P_STEP, 1'b0);
    endtask : seq_step
    task automatic strobe_pulse();
        put(P_STRB, 1'b1);
        put(P_STRB, 1'b0);
    endtask : strobe_pulse
    task automatic gate_direct(input logic v);
        put(P_GDIR, v);
    endtask : gate_direct
    task automatic gate_delayed(input logic v);
        put(P_GDLY, v);
    endtask : gate_delayed
    // first bit out lands in the top bit; both enable styles as two latches would see
    task automatic shift_word(input logic [13:0] w, input logic ceh, input logic cel);
        put(P_CEH, ceh);
        put(P_CEL, cel);
        for (int i = 13; i >= 0; i--) begin
            put(P_DATA, w[i]);
            put(P_SCLK, 1'b1);
            put(P_SCLK, 1'b0);
        end
        // released data line shows the inverse, never the last bit
        put(P_DATA, ~w[0]);
    endtask : shift_word
endmodule : vfdsl_ctrl_model
`default_nettype wire

// ===== sim/vfdsl_top_tb.sv
// self-checking bench for the grid sequencer and segment latch
`timescale 1ns/10ps
`default_nettype none
module vfdsl_top_tb;
    import vfdsl_pkg::*;
    localparam logic [VFDSL_DLY_W-1:0] DLY_RST = 16'h0010;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [VFDSL_ADDR_W-1:0] addr = '0;
    logic [VFDSL_DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [VFDSL_DATA_W-1:0] rdata;
    vfdsl_pins_s pins;
    logic [VFDSL_GRIDS-1:0] grid;
    logic [VFDSL_SEGS-1:0] seg;
    int fail_count = 0;
    int n_tests = 0;
    always #4 clk = ~clk;
    // link clock offset from the core clock edges
    initial begin
        #3.7;
        forever #15 link_clk = ~link_clk;
    end
    vfdsl_top #(.DELAY_RESET(DLY_RST)) i_dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_LINK_CLK(link_clk),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata),
        .I_PINS(pins), .O_GRID(grid), .O_SEGMENT(seg));
    vfdsl_ctrl_model i_ctrl (.i_link_clk(link_clk), .o_pins(pins));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic reg_wr(input logic [VFDSL_ADDR_W-1:0] a, input logic [VFDSL_DATA_W-1:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr
    // read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [VFDSL_ADDR_W-1:0] a, output logic [VFDSL_DATA_W-1:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : reg_rd
    task automatic lwait(input int n);
        repeat (n) @(posedge link_clk);
    endtask : lwait
    // bounded wait for the grids to come back after blanking
    task automatic wait_grid(output int n);
        n = 0;
        while (grid === '0 && n < 300) begin
            @(posedge link_clk);
            n++;
        end
    endtask : wait_grid
    function automatic logic [13:0] grid_at(input int p);
        return 14'h0001 << p;
    endfunction : grid_at
    initial begin : main
        logic [31:0] v;
        logic [13:0] w;
        logic [13:0] sr, held;
        logic [1:0] modes [4];
        int pos;
        int d;
        int c_dir, c_del;
        modes = '{2'b11, 2'b00, 2'b10, 2'b01};
        void'($urandom(54771));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        lwait(4);
        // reset value, readback, ignored write to status, unmapped read
        reg_rd(VFDSL_ADDR_CTRL, v);
        check(v, {16'h0, DLY_RST}, "ctrl reset");
        d = 8 + int'($urandom % 24);
        reg_wr(VFDSL_ADDR_CTRL, 32'(d));
        reg_wr(VFDSL_ADDR_STATUS, 32'hffffffff);
        reg_rd(VFDSL_ADDR_CTRL, v);
        check(v, 32'(d), "ctrl readback");
        reg_rd(4'hc, v);
        check(v, 32'h0, "unmapped read");
        // sync, walk across the wrap, then sync again from mid-ring
        i_ctrl.sync_pulse();
        lwait(4);
        check(32'(grid), 32'(grid_at(0)), "grid after sync");
        pos = 0;
        for (int i = 0; i < 17; i++) begin
            i_ctrl.seq_step();
            lwait(4);
            pos = (pos + 1) % 14;
            check(32'(grid), 32'(grid_at(pos)), "grid step");
        end
        i_ctrl.sync_pulse();
        lwait(4);
        check(32'(grid), 32'(grid_at(0)), "grid after mid sync");
        // dark while blanked, counter still moving underneath
        i_ctrl.gate_direct(1'b1);
        lwait(4);
        for (int i = 0; i < 3; i++) begin
            i_ctrl.seq_step();
        end
        check(32'(grid), 32'h0, "direct blank");
        i_ctrl.gate_direct(1'b0);
        wait_grid(c_dir);
        check(32'(grid), 32'(grid_at(3)), "counter ran while blanked");
        i_ctrl.gate_delayed(1'b1);
        lwait(4);
        check(32'(grid), 32'h0, "delayed blank");
        i_ctrl.gate_delayed(1'b0);
        wait_grid(c_del);
        check(32'((c_del - c_dir >= d) && (c_del - c_dir <= d + 3)), 32'h1, "release delay");
        // each enable style, shifting without strobe, shifting while disabled
        sr = '0;
        held = '0;
        for (int m = 0; m < 4; m++) begin
            w = (m == 0) ? 14'h2001 : 14'($urandom);
            i_ctrl.shift_word(w, modes[m][1], modes[m][0]);
            if (modes[m] != 2'b01) begin
                sr = w;
            end
            i_ctrl.strobe_pulse();
            lwait(4);
            held = sr;
            check(32'(seg), 32'(held), "latch after strobe");
            i_ctrl.shift_word(~w, 1'b1, 1'b0);
            sr = ~w;
            check(32'(seg), 32'(held), "latch holds between strobes");
        end
        lwait(20);
        reg_rd(VFDSL_ADDR_SEGS, v);
        check(v, 32'(held), "segs register");
        reg_rd(VFDSL_ADDR_STATUS, v);
        check(v, {19'h0, 8'h04, 1'b0, 4'h3}, "status register");
        end_sim();
    end
    initial begin : watchdog
        #400000;
        fail_count++;
        $display("wrong value at %0t: run did not finish", $time);
        end_sim();
    end
endmodule : vfdsl_top_tb
`default_nettype wire
